/* hdl/hcp_cursor_ctrl.sv */
// Cursor command, cursor position and cross-hair window position registers
//
// Contract
// - Eight-bit command register, read and written anytime
// - Bits 7,6 enable pattern cursor planes
// - Bits 5,4 enable identical cross-hair planes
// - Bit 3 selects XOR or OR combining
// - Bits 2:1 give thickness 1,3,5,7
// - Bit 0 blinks every displayed cursor
// - Cursor coordinate is pattern centre, hair crossing
// - Cursor moves at retrace after vertical-high write
// - Cursor coordinates 12 bits, high nibble reads zero
// - Horizontal cursor reference adds 37, 52, 57
// - Horizontal cursor accepts 000 through FFF
// - Vertical cursor reference adds back 32
// - Vertical cursor FC0..FFF are negative
// - Window coordinate is cross-hair window corner
// - Window moves at retrace after vertical-high write
// - Window coordinates 12 bits, high nibble reads zero
// - Horizontal window reference adds 5, 20, 25
// - Vertical window reference adds nothing
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "hcp_regs.svh"
module hcp_cursor_ctrl
  import hcp_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  // Video timing
  input  wire logic          vsync_n_pin,
  input  wire hcp_mux_type   mux_mode,
  input  wire logic          blink_phase,
  // Cursor state toward the pixel pipeline
  output hcp_view_type       view,
  output hcp_coord_type      cursor_pos,
  output hcp_coord_type      window_pos,
  output hcp_ref_type        cursor_ref,
  output hcp_ref_type        window_ref,
  output hcp_ref_type        cursor_box,
  output logic [1:0]         update_pending
);

  hcp_ctrl_type  ctrl_ff;
  hcp_coord_type cur_hold_ff;
  hcp_coord_type win_hold_ff;
  logic          cur_pend_ff;
  logic          win_pend_ff;
  logic          retrace;
  logic [7:0]    nxt_rdata;
  logic          blink_ok;
  hcp_ref_type   nxt_cursor_ref;
  hcp_ref_type   nxt_window_ref;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic [12:0] pipe_const(input hcp_mux_type m, input logic is_win);
    if (m == HCP_MUX_4TO1) begin
      pipe_const = is_win ? `HCP_WIN_P_4TO1 : `HCP_CUR_P_4TO1;
    end else if (m == HCP_MUX_5TO1) begin
      pipe_const = is_win ? `HCP_WIN_P_5TO1 : `HCP_CUR_P_5TO1;
    end else begin
      pipe_const = is_win ? `HCP_WIN_P_1TO1 : `HCP_CUR_P_1TO1;
    end
  endfunction

  // Top codes of the vertical cursor stand for rows above the screen
  function automatic logic [12:0] vert_signed(input logic [11:0] v);
    vert_signed = {(v[11:6] == `HCP_NEG_TOP), v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Retrace detection

  hcp_retrace_det u_retrace (
    .clock         (clock),
    .rst_n         (rst_n),
    .vsync_n_pin   (vsync_n_pin),
    .retrace_pulse (retrace)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command register

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff <= hcp_ctrl_type'(`HCP_RST_BYTE);
    end else if (reg_wr && hit(reg_addr, `HCP_OFS_CTRL)) begin
      ctrl_ff <= hcp_ctrl_type'(reg_wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding registers

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur_hold_ff <= {`HCP_RST_COORD, `HCP_RST_COORD};
    end else if (reg_wr) begin
      if (hit(reg_addr, `HCP_OFS_CUR_XL)) begin
        cur_hold_ff.x[7:0] <= reg_wdata;
      end else if (hit(reg_addr, `HCP_OFS_CUR_XH)) begin
        cur_hold_ff.x[11:8] <= reg_wdata[3:0];
      end else if (hit(reg_addr, `HCP_OFS_CUR_YL)) begin
        cur_hold_ff.y[7:0] <= reg_wdata;
      end else if (hit(reg_addr, `HCP_OFS_CUR_YH)) begin
        cur_hold_ff.y[11:8] <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      win_hold_ff <= {`HCP_RST_COORD, `HCP_RST_COORD};
    end else if (reg_wr) begin
      if (hit(reg_addr, `HCP_OFS_WIN_XL)) begin
        win_hold_ff.x[7:0] <= reg_wdata;
      end else if (hit(reg_addr, `HCP_OFS_WIN_XH)) begin
        win_hold_ff.x[11:8] <= reg_wdata[3:0];
      end else if (hit(reg_addr, `HCP_OFS_WIN_YL)) begin
        win_hold_ff.y[7:0] <= reg_wdata;
      end else if (hit(reg_addr, `HCP_OFS_WIN_YH)) begin
        win_hold_ff.y[11:8] <= reg_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Deferred update: a vertical-high write arms, retrace transfers

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur_pend_ff <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `HCP_OFS_CUR_YH)) begin
      cur_pend_ff <= 1'b1;
    end else if (retrace) begin
      cur_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      win_pend_ff <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `HCP_OFS_WIN_YH)) begin
      win_pend_ff <= 1'b1;
    end else if (retrace) begin
      win_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cursor_pos <= {`HCP_RST_COORD, `HCP_RST_COORD};
    end else if (retrace && cur_pend_ff) begin
      cursor_pos <= cur_hold_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      window_pos <= {`HCP_RST_COORD, `HCP_RST_COORD};
    end else if (retrace && win_pend_ff) begin
      window_pos <= win_hold_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      update_pending <= 2'h0;
    end else begin
      update_pending <= {win_pend_ff, cur_pend_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Position references against the sync-relative pixel and line counts

  always_comb begin
    nxt_cursor_ref.x = {1'b0, cursor_pos.x} + pipe_const(mux_mode, 1'b0);
    nxt_cursor_ref.y = vert_signed(cursor_pos.y) + `HCP_CUR_V_OFS;
    nxt_window_ref.x = {1'b0, window_pos.x} + pipe_const(mux_mode, 1'b1);
    nxt_window_ref.y = {1'b0, window_pos.y};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cursor_ref <= {`HCP_RST_REF, `HCP_RST_REF};
      window_ref <= {`HCP_RST_REF, `HCP_RST_REF};
    end else begin
      cursor_ref <= nxt_cursor_ref;
      window_ref <= nxt_window_ref;
    end
  end

  // Upper-left corner of the 64x64 pattern box centred on the cursor
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cursor_box <= {`HCP_RST_REF, `HCP_RST_REF};
    end else begin
      cursor_box.x <= nxt_cursor_ref.x - `HCP_BOX_HALF;
      cursor_box.y <= nxt_cursor_ref.y - `HCP_BOX_HALF;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display controls

  assign blink_ok = ~ctrl_ff.cursor_blink_on | blink_phase;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      view <= hcp_view_type'(7'h00);
    end else begin
      view.pattern_show <= {ctrl_ff.pattern_plane1_show, ctrl_ff.pattern_plane0_show} & {2{blink_ok}};
      view.hair_show    <= (ctrl_ff.hair_plane1_show | ctrl_ff.hair_plane0_show) & blink_ok;
      view.combine_or   <= ctrl_ff.combine_format;
      view.hair_width   <= {ctrl_ff.hair_thickness, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port; holding values read back, high nibbles read zero

  always_comb begin
    nxt_rdata = `HCP_RST_BYTE;
    if (reg_rd) begin
      if (hit(reg_addr, `HCP_OFS_CTRL)) begin
        nxt_rdata = ctrl_ff;
      end else if (hit(reg_addr, `HCP_OFS_CUR_XL)) begin
        nxt_rdata = cur_hold_ff.x[7:0];
      end else if (hit(reg_addr, `HCP_OFS_CUR_XH)) begin
        nxt_rdata = {4'h0, cur_hold_ff.x[11:8]};
      end else if (hit(reg_addr, `HCP_OFS_CUR_YL)) begin
        nxt_rdata = cur_hold_ff.y[7:0];
      end else if (hit(reg_addr, `HCP_OFS_CUR_YH)) begin
        nxt_rdata = {4'h0, cur_hold_ff.y[11:8]};
      end else if (hit(reg_addr, `HCP_OFS_WIN_XL)) begin
        nxt_rdata = win_hold_ff.x[7:0];
      end else if (hit(reg_addr, `HCP_OFS_WIN_XH)) begin
        nxt_rdata = {4'h0, win_hold_ff.x[11:8]};
      end else if (hit(reg_addr, `HCP_OFS_WIN_YL)) begin
        nxt_rdata = win_hold_ff.y[7:0];
      end else if (hit(reg_addr, `HCP_OFS_WIN_YH)) begin
        nxt_rdata = {4'h0, win_hold_ff.y[11:8]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= `HCP_RST_BYTE;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_ctrl_readback: assert property (
    reg_wr && hit(reg_addr, `HCP_OFS_CTRL) ##1 reg_rd && hit(reg_addr, `HCP_OFS_CTRL)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("command register does not read back its write");

  a_pattern_gate: assert property (
    ctrl_ff.pattern_plane1_show && !ctrl_ff.cursor_blink_on |=> view.pattern_show[1])
    else $error("enabled pattern plane not shown");

  a_hair_either: assert property (
    (ctrl_ff.hair_plane1_show ^ ctrl_ff.hair_plane0_show) && blink_phase |=> view.hair_show)
    else $error("single cross-hair plane enable does not show hair");

  a_combine_sel: assert property (
    reg_wr && hit(reg_addr, `HCP_OFS_CTRL) |=> ##1 view.combine_or == $past(reg_wdata[3], 2))
    else $error("combine format does not follow bit three");

  a_hair_width: assert property (
    reg_wr && hit(reg_addr, `HCP_OFS_CTRL)
    |=> ##1 view.hair_width == 3'(2 * $past(reg_wdata[2:1], 2) + 1))
    else $error("cross-hair width not 1, 3, 5 or 7");

  a_blink_hide: assert property (
    ctrl_ff.cursor_blink_on && !blink_phase |=> view.pattern_show == 2'h0 && !view.hair_show)
    else $error("cursor visible in blink-off phase");

  a_box_centre: assert property (
    rst_n |=> cursor_box.x + `HCP_BOX_HALF == cursor_ref.x && cursor_box.y + `HCP_BOX_HALF == cursor_ref.y)
    else $error("pattern box not centred on cursor");

  a_cursor_hold: assert property (
    !(retrace && cur_pend_ff) |=> $stable(cursor_pos))
    else $error("cursor moved outside retrace");

  a_cursor_xfer: assert property (
    retrace && cur_pend_ff |=> cursor_pos == $past(cur_hold_ff) ##1 !cur_pend_ff || update_pending[0])
    else $error("cursor pair did not transfer together");

  a_high_nibble: assert property (
    reg_rd && (hit(reg_addr, `HCP_OFS_CUR_XH) || hit(reg_addr, `HCP_OFS_WIN_YH)) |=> reg_rdata[7:4] == 4'h0)
    else $error("high byte upper nibble not zero");

  a_cur_ref_x: assert property (
    rst_n && mux_mode == HCP_MUX_5TO1 |=> cursor_ref.x == $past({1'b0, cursor_pos.x}) + 13'h0039)
    else $error("horizontal cursor reference wrong for 5:1");

  a_cur_ref_y: assert property (
    cursor_pos.y[11:6] == `HCP_NEG_TOP |=> cursor_ref.y < `HCP_CUR_V_OFS || cursor_ref.y[12])
    else $error("negative vertical cursor not above screen");

  a_win_ref: assert property (
    rst_n && mux_mode == HCP_MUX_1TO1 |=> window_ref.x == $past({1'b0, window_pos.x}) + 13'h0005)
    else $error("horizontal window reference wrong for 1:1");

  a_win_ref_y: assert property (
    rst_n |=> window_ref.y == {1'b0, $past(window_pos.y)})
    else $error("vertical window reference has an offset");

  a_window_hold: assert property (
    reg_wr && hit(reg_addr, `HCP_OFS_WIN_YH) && !retrace |=> win_pend_ff [*1] ##0 $stable(window_pos))
    else $error("window moved before retrace");

  c_cursor_move: cover property (retrace && cur_pend_ff ##1 $changed(cursor_pos));
  c_window_move: cover property (retrace && win_pend_ff);
  c_write_at_retrace: cover property (retrace && reg_wr && hit(reg_addr, `HCP_OFS_CUR_YH));
  c_cursor_above: cover property (cursor_pos.y[11:6] == `HCP_NEG_TOP && view.pattern_show != 2'h0);

endmodule

/* hdl/hcp_regs.svh */
// Register offsets, field constants, reset values and pipeline constants of the cursor position block
`ifndef HCP_REGS_SVH
`define HCP_REGS_SVH

`define HCP_OFS_CTRL       4'h0
`define HCP_OFS_CUR_XL     4'h1
`define HCP_OFS_CUR_XH     4'h2
`define HCP_OFS_CUR_YL     4'h3
`define HCP_OFS_CUR_YH     4'h4
`define HCP_OFS_WIN_XL     4'h5
`define HCP_OFS_WIN_XH     4'h6
`define HCP_OFS_WIN_YL     4'h7
`define HCP_OFS_WIN_YH     4'h8

`define HCP_HI_MASK        8'h0F
`define HCP_RST_BYTE       8'h00
`define HCP_RST_COORD      12'h000
`define HCP_RST_REF        13'h0000

`define HCP_CUR_P_1TO1     13'h0025
`define HCP_CUR_P_4TO1     13'h0034
`define HCP_CUR_P_5TO1     13'h0039
`define HCP_WIN_P_1TO1     13'h0005
`define HCP_WIN_P_4TO1     13'h0014
`define HCP_WIN_P_5TO1     13'h0019
`define HCP_CUR_V_OFS      13'h0020
`define HCP_BOX_HALF       13'h0020
`define HCP_NEG_TOP        6'h3F

`endif

/* hdl/hcp_pkg.sv */
// Types shared by the cursor position block
package hcp_pkg;

  typedef enum logic [1:0] {
    HCP_MUX_1TO1,
    HCP_MUX_4TO1,
    HCP_MUX_5TO1
  } hcp_mux_type;

  typedef struct packed {
    logic       pattern_plane1_show;
    logic       pattern_plane0_show;
    logic       hair_plane1_show;
    logic       hair_plane0_show;
    logic       combine_format;
    logic [1:0] hair_thickness;
    logic       cursor_blink_on;
  } hcp_ctrl_type;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
  } hcp_coord_type;

  typedef struct packed {
    logic [12:0] x;
    logic [12:0] y;
  } hcp_ref_type;

  typedef struct packed {
    logic [1:0] pattern_show;
    logic       hair_show;
    logic       combine_or;
    logic [2:0] hair_width;
  } hcp_view_type;

endpackage

/* hdl/hcp_retrace_det.sv */
// Vertical sync pin synchroniser and retrace start detector
`timescale 1ns/1ns
module hcp_retrace_det (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Sync pin, active low
  input  wire logic vsync_n_pin,
  // One-cycle pulse at the start of vertical retrace
  output logic      retrace_pulse
);

  logic sync1_ff;
  logic sync2_ff;
  logic last_ff;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= vsync_n_pin;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last_ff <= 1'b1;
    end else begin
      last_ff <= sync2_ff;
    end
  end

  // Falling edge of the synchronised sync marks retrace
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      retrace_pulse <= 1'b0;
    end else begin
      retrace_pulse <= last_ff & ~sync2_ff;
    end
  end

endmodule

/* testbench/hcp_video_model.sv */
// Video timing model that makes one vertical sync pulse per requested frame
`timescale 1ns/1ns
module hcp_video_model (
  // Clock
  input  wire logic clock,
  // Frame request, one cycle
  input  wire logic frame_go,
  // Sync pin, active low
  output logic      vsync_n_pin
);
  logic [2:0] low_cnt_ff = 3'h0;

  always_ff @(posedge clock) begin
    if (frame_go) begin
      low_cnt_ff <= 3'h4;
    end else if (low_cnt_ff != 3'h0) begin
      low_cnt_ff <= low_cnt_ff - 3'h1;
    end
  end

  // Sync low for four cycles marks the start of vertical retrace
  assign vsync_n_pin = (low_cnt_ff == 3'h0);
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the cursor position block
`timescale 1ns/1ns
module testbench;
  import hcp_pkg::*;

  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] r; logic b;} hcp_row_type;

  logic          clock;
  logic          rst_n;
  logic [3:0]    reg_addr;
  logic [7:0]    reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [7:0]    reg_rdata;
  logic          vsync_n_pin;
  hcp_mux_type   mux_mode;
  logic          blink_phase;
  logic          frame_go;
  hcp_view_type  view;
  hcp_coord_type cursor_pos;
  hcp_coord_type window_pos;
  hcp_ref_type   cursor_ref;
  hcp_ref_type   window_ref;
  hcp_ref_type   cursor_box;
  logic [1:0]    update_pending;
  int            bad_count;
  int            checks_done;
  logic [7:0]    rd_val;
  logic [12:0]   cp [3];
  logic [12:0]   wp [3];
  hcp_row_type   rows [18];

  hcp_cursor_ctrl #(.ADDR_W(4)) hcp_cursor_ctrl_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vsync_n_pin(vsync_n_pin),
    .mux_mode(mux_mode), .blink_phase(blink_phase), .view(view), .cursor_pos(cursor_pos),
    .window_pos(window_pos), .cursor_ref(cursor_ref), .window_ref(window_ref),
    .cursor_box(cursor_box), .update_pending(update_pending)
  );

  hcp_video_model hcp_video_model_i (
    .clock(clock), .frame_go(frame_go), .vsync_n_pin(vsync_n_pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Caller stands just after a rising edge; the write strobe stays up for a write that follows
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
    @(posedge clock);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  // Display controls expected from a command byte and the blink phase
  function automatic logic [6:0] view_exp(input logic [7:0] c, input logic b);
    logic s;
    s = ~c[0] | b;
    return {c[7:6] & {2{s}}, (c[5] | c[4]) & s, c[3], c[2:1], 1'b1};
  endfunction

  // Reference pair: x plus px, y (signed when sy and in the negative band) plus py
  function automatic logic [25:0] ref_of(input hcp_coord_type p, input logic [12:0] px,
                                         input logic [12:0] py, input logic sy);
    return {{1'b0, p.x} + px, {sy & (p.y[11:6] == 6'h3F), p.y} + py};
  endfunction

  task automatic chk_pos(input logic [11:0] cx, cy, wx, wy);
    hcp_coord_type c;
    hcp_coord_type w;
    c = {cx, cy};
    w = {wx, wy};
    chk(cursor_pos, c);
    chk(window_pos, w);
    chk(update_pending, 2'h0);
    chk(cursor_ref, ref_of(c, cp[mux_mode], 13'h0020, 1'b1));
    chk(cursor_box, ref_of(c, cp[mux_mode] - 13'h0020, 13'h0000, 1'b1));
    chk(window_ref, ref_of(w, wp[mux_mode], 13'h0000, 1'b0));
  endtask

  task automatic chk_zero();
    chk(view, 7'h00);
    chk(cursor_pos, 24'h000000);
    chk(window_pos, 24'h000000);
    chk(reg_rdata, 8'h00);
  endtask

  task automatic frame();
    int n;
    idle(1);
    frame_go <= 1'b1;
    @(posedge clock);
    frame_go <= 1'b0;
    n = 0;
    while (update_pending !== 2'h0 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n == 40) begin
      chk(32'h1, 32'h0);
      results();
    end
    repeat (12) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    rst_n       = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    mux_mode    = HCP_MUX_1TO1;
    blink_phase = 1'b1;
    frame_go    = 1'b0;
    bad_count   = 0;
    checks_done = 0;
    cp = '{13'h0025, 13'h0034, 13'h0039};
    wp = '{13'h0005, 13'h0014, 13'h0019};
    rows = '{'{4'h0, 8'hC0, 8'hC0, 1'b1}, '{4'h0, 8'h10, 8'h10, 1'b1}, '{4'h0, 8'h20, 8'h20, 1'b1},
             '{4'h0, 8'h4A, 8'h4A, 1'b1}, '{4'h0, 8'h84, 8'h84, 1'b1}, '{4'h0, 8'hFF, 8'hFF, 1'b0},
             '{4'h0, 8'hC1, 8'hC1, 1'b1}, '{4'h0, 8'h36, 8'h36, 1'b0},
             '{4'h1, 8'h34, 8'h34, 1'b1}, '{4'h2, 8'hFF, 8'h0F, 1'b1}, '{4'h3, 8'h56, 8'h56, 1'b1},
             '{4'h4, 8'hF3, 8'h03, 1'b1}, '{4'h5, 8'h12, 8'h12, 1'b1}, '{4'h6, 8'hA1, 8'h01, 1'b1},
             '{4'h7, 8'h78, 8'h78, 1'b1}, '{4'h8, 8'h02, 8'h02, 1'b1}, '{4'h9, 8'h5A, 8'h00, 1'b1},
             '{4'hF, 8'h5A, 8'h00, 1'b1}};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk_zero();
    $display("test reset done");
    @(posedge clock);
    foreach (rows[i]) begin
      blink_phase <= rows[i].b;
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rd_val, rows[i].r);
      if (rows[i].a == 4'h0) begin
        chk(view, view_exp(rows[i].d, rows[i].b));
      end
    end
    $display("test register table done");
    chk(cursor_pos, 24'h000000);
    chk(update_pending, 2'h3);
    frame();
    chk_pos(12'hF34, 12'h356, 12'h112, 12'h278);
    $display("test deferred update done");
    wr(4'h3, 8'hC0);
    wr(4'h4, 8'h0F);
    wr(4'h5, 8'h99);
    mux_mode <= HCP_MUX_4TO1;
    frame();
    chk_pos(12'hF34, 12'hFC0, 12'h112, 12'h278);
    mux_mode <= HCP_MUX_5TO1;
    idle(4);
    chk_pos(12'hF34, 12'hFC0, 12'h112, 12'h278);
    $display("test negative row and modes done");
    wr(4'h1, 8'hFF);
    wr(4'h3, 8'hBF);
    wr(4'h4, 8'h0F);
    wr(4'h8, 8'h02);
    frame();
    chk_pos(12'hFFF, 12'hFBF, 12'h199, 12'h278);
    wr(4'h1, 8'h00);
    frame();
    chk_pos(12'hFFF, 12'hFBF, 12'h199, 12'h278);
    $display("test coordinate limits done");
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    @(negedge clock);
    chk_zero();
    $display("test mid-run reset done");
    results();
  end
endmodule
